// >>> common/charger_ctrl_pkg.sv
// Constants and types shared by the charger control logic
// ****************************************************************
// Notes on behaviour
// - High-impedance request bit at 1 puts the device in high-impedance state.
// - High-impedance stops converter, ADC, gate drives and regulator output.
// - High-impedance exits only on host clearing request or power-on reset.
// - Any fault stops converter and clears charge enable; regulator stays on.
// - Supply rising above lockout resets all registers and readies the port.
// - Each event pulls the event pin low for 256 us, then releases it; an event during a running pulse starts no new pulse.
// - Alarm indications are spaced at least 120 ms apart.
// - Battery overcurrent is acted on within 640 us.
// - Adapter overvoltage is acted on within 100 ns.
// - Host picks the active input; after reset input 1 is primary.
// - At power-on, grounded gate pins are sensed and fitted flags recorded.
// - A single GaN switch is handled exactly like a switch pair.
// - Four input arrangements are supported, from no switch to two pairs.
// - A gate drive turns on only if its switch is fitted.
// - Charging continues only while input current exceeds undercurrent limit.
// - Gate on also needs adapter valid, no disable, no high-z, bus absent.
// ****************************************************************
package charger_ctrl_pkg;
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned EVENT_PULSE_US = 256;
  localparam int unsigned ALARM_GAP_MS = 120;
  localparam int unsigned BAT_OCP_RESP_US = 640;
  localparam int unsigned ADP_OVP_RESP_NS = 100;
  localparam int unsigned EVENT_PULSE_CYC = EVENT_PULSE_US * CLK_MHZ;
  localparam int unsigned ALARM_GAP_CYC = ALARM_GAP_MS * 1000 * CLK_MHZ;
  // Longest times round down
  localparam int unsigned BAT_OCP_CYC = BAT_OCP_RESP_US * CLK_MHZ;
  localparam int unsigned ADP_OVP_CYC = (ADP_OVP_RESP_NS * CLK_MHZ) / 1000;
  localparam int unsigned SENSE_CYC = 16;
  localparam logic [1:0] SOURCE_RESET = 2'h0;
  localparam logic HIZ_RESET = 1'h0;
  localparam logic CHARGE_ENABLE_RESET = 1'h0;
  typedef enum logic [1:0] {
    PWR_SENSE = 2'b00,
    PWR_LATCH = 2'b01,
    PWR_READY = 2'b10
  } power_state_t;
endpackage : charger_ctrl_pkg

// >>> rtl/pulse_timer.sv
// Retriggerable-blocking one-shot timer of programmable length
`timescale 1ns/1ns
`default_nettype none
module pulse_timer #(
  parameter int unsigned LENGTH = 64000,
  parameter int unsigned WIDTH = 32
) (
  input wire logic clk, // Clock
  input wire logic rst_n, // Async reset, active low
  input wire logic start, // Start request
  output logic busy // High while timing
);
  logic [WIDTH-1:0] count;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      busy <= 1'b0;
    end else if (busy) begin
      if (count == WIDTH'(LENGTH - 1)) begin
        busy <= 1'b0;
        count <= '0;
      end else begin
        count <= count + WIDTH'(1);
      end
    end else if (start) begin
      busy <= 1'b1;
      count <= '0;
    end
  end
endmodule : pulse_timer
`default_nettype wire

// >>> rtl/charger_ctrl.sv
// Charger high-impedance, fault, event timing and input switch control
`timescale 1ns/1ns
`default_nettype none
module charger_ctrl #(
  parameter int unsigned EVENT_CYC = charger_ctrl_pkg::EVENT_PULSE_CYC,
  parameter int unsigned ALARM_CYC = charger_ctrl_pkg::ALARM_GAP_CYC,
  parameter int unsigned OCP_CYC = charger_ctrl_pkg::BAT_OCP_CYC
) (
  input wire logic clk, // 250 MHz clock
  input wire logic rst_n, // Power-on reset, active low
  input wire logic hiz_wr, // Host write strobe, high-z bit
  input wire logic hiz_wdata, // Value written to high-z bit
  input wire logic charge_enable_wr, // Host write strobe, charge enable
  input wire logic charge_enable_wdata, // Value written to charge enable
  input wire logic dis_wr, // Host write strobe, switch disable
  input wire logic dis_wdata, // Value for both_switch_disable
  input wire logic src_wr, // Host write strobe, source select
  input wire logic [1:0] src_wdata, // Bit0 gate 1 on, bit1 gate 2 on unless gate 1 on; 0 = input 1 first
  input wire logic fault_in, // Any other fault, async pin
  input wire logic bat_ocp_in, // Battery overcurrent comparator
  input wire logic adp_ovp1_in, // Adapter 1 overvoltage comparator
  input wire logic adp_ovp2_in, // Adapter 2 overvoltage comparator
  input wire logic bus_ucp_in, // Input current below limit
  input wire logic adp1_present_in, // Adapter 1 present
  input wire logic adp2_present_in, // Adapter 2 present
  input wire logic adp1_tied_bus_in, // Adapter 1 tied to bus node
  input wire logic adp2_tied_bus_in, // Adapter 2 tied to bus node
  input wire logic bus_present_in, // Bus node above presence level
  input wire logic out_present_in, // Output above presence level
  input wire logic gate1_grounded_in, // Gate 1 pin sensed at ground
  input wire logic gate2_grounded_in, // Gate 2 pin sensed at ground
  input wire logic alarm_event_in, // Alarm condition event
  output logic high_impedance_request, // High-z request bit
  output logic charge_enable, // Charge enable bit
  output logic both_switch_disable, // Both-switch disable bit
  output logic converter_run, // Converter switching allowed
  output logic adc_run, // ADC conversions allowed
  output logic internal_regulator_out, // Regulator enable
  output logic gate_drive1, // Input switch 1 gate drive
  output logic gate_drive2, // Input switch 2 gate drive
  output logic input1_switch_fitted_flag, // Switch 1 fitted
  output logic input2_switch_fitted_flag, // Switch 2 fitted
  output logic bus_supply_present_flag, // Bus supply present
  output logic output_supply_present_flag, // Output supply present
  output logic host_port_ready, // Host register port usable
  output logic event_pulse_out_n, // Event pin, low while active
  output logic alarm_indication // One-cycle alarm indication
);
  import charger_ctrl_pkg::*;

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  localparam int NS = 14;
  logic [NS-1:0] raw;
  logic [NS-1:0] sync1;
  logic [NS-1:0] sync2;
  assign raw = {fault_in, bat_ocp_in, adp_ovp1_in, adp_ovp2_in, bus_ucp_in,
                adp1_present_in, adp2_present_in, adp1_tied_bus_in,
                adp2_tied_bus_in, bus_present_in, out_present_in,
                gate1_grounded_in, gate2_grounded_in, alarm_event_in};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= raw;
      sync2 <= sync1;
    end
  end

  logic s_fault, s_ocp, s_ovp1, s_ovp2, s_ucp, s_p1, s_p2, s_t1, s_t2;
  logic s_bus, s_out, s_g1, s_g2, s_alarm;
  assign {s_fault, s_ocp, s_ovp1, s_ovp2, s_ucp, s_p1, s_p2, s_t1, s_t2,
          s_bus, s_out, s_g1, s_g2, s_alarm} = sync2;

  // ****************************************************************
  // Power-on sequence and switch detection
  // ****************************************************************
  power_state_t pstate;
  logic [4:0] sense_cnt;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pstate <= PWR_SENSE;
      sense_cnt <= '0;
    end else begin
      case (pstate)
        PWR_SENSE: begin
          sense_cnt <= sense_cnt + 5'h1;
          if (sense_cnt == 5'(SENSE_CYC - 1)) pstate <= PWR_LATCH;
        end
        PWR_LATCH: pstate <= PWR_READY;
        PWR_READY: pstate <= PWR_READY;
        default: pstate <= PWR_SENSE;
      endcase
    end
  end

  // Fitted when gate pin not grounded; GaN and pair alike
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      input1_switch_fitted_flag <= 1'b0;
      input2_switch_fitted_flag <= 1'b0;
    end else if (pstate == PWR_LATCH) begin
      input1_switch_fitted_flag <= !s_g1;
      input2_switch_fitted_flag <= !s_g2;
    end
  end

  logic ready;
  assign ready = (pstate == PWR_READY);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      host_port_ready <= 1'b0;
      bus_supply_present_flag <= 1'b0;
      output_supply_present_flag <= 1'b0;
    end else begin
      host_port_ready <= ready;
      bus_supply_present_flag <= s_bus;
      output_supply_present_flag <= s_out;
    end
  end

  // ****************************************************************
  // Control bits
  // ****************************************************************
  logic ocp_trip;
  logic fault_any;
  assign fault_any = s_fault | ocp_trip | s_ovp1 | s_ovp2 | s_ucp;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      high_impedance_request <= HIZ_RESET;
    end else if (ready && hiz_wr) begin
      high_impedance_request <= hiz_wdata;
    end
  end

  // Fault clear wins over a host set in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      charge_enable <= CHARGE_ENABLE_RESET;
    end else if (fault_any) begin
      charge_enable <= 1'b0;
    end else if (ready && charge_enable_wr) begin
      charge_enable <= charge_enable_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      both_switch_disable <= 1'b0;
    end else if (ready && dis_wr) begin
      both_switch_disable <= dis_wdata;
    end
  end

  // Host source choice, input 1 primary by default
  logic [1:0] src_sel;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      src_sel <= SOURCE_RESET;
    end else if (ready && src_wr) begin
      src_sel <= src_wdata;
    end
  end

  // ****************************************************************
  // Battery overcurrent response delay
  // ****************************************************************
  logic [31:0] ocp_cnt;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ocp_cnt <= '0;
      ocp_trip <= 1'b0;
    end else if (!s_ocp) begin
      ocp_cnt <= '0;
      ocp_trip <= 1'b0;
    end else if (ocp_cnt >= 32'(OCP_CYC - 4)) begin
      ocp_trip <= 1'b1;
    end else begin
      ocp_cnt <= ocp_cnt + 32'h1;
    end
  end

  // ****************************************************************
  // Converter, ADC and regulator enables
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      converter_run <= 1'b0;
      adc_run <= 1'b0;
      internal_regulator_out <= 1'b0;
    end else begin
      converter_run <= ready && !high_impedance_request && !fault_any
                       && charge_enable;
      adc_run <= ready && !high_impedance_request;
      internal_regulator_out <= ready && !high_impedance_request;
    end
  end

  // ****************************************************************
  // Input switch gate drives
  // ****************************************************************
  logic ok1, ok2, want1, want2;
  assign ok1 = ready && input1_switch_fitted_flag && !s_t1 && s_p1
               && !s_ovp1 && !both_switch_disable
               && !high_impedance_request && !s_bus;
  assign ok2 = ready && input2_switch_fitted_flag && !s_t2 && s_p2
               && !s_ovp2 && !both_switch_disable
               && !high_impedance_request && !s_bus;
  // Default: input 1 first, input 2 only if 1 cannot run
  assign want1 = (src_sel == SOURCE_RESET) ? ok1 : (src_sel[0] && ok1);
  assign want2 = (src_sel == SOURCE_RESET) ? (ok2 && !ok1)
                                            : (src_sel[1] && ok2 && !want1);

  // Registered, so any condition loss drops the drive next edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gate_drive1 <= 1'b0;
      gate_drive2 <= 1'b0;
    end else begin
      gate_drive1 <= want1;
      gate_drive2 <= want2;
    end
  end

  // ****************************************************************
  // Event pulse and alarm spacing
  // ****************************************************************
  logic fault_d, alarm_d, ev_start, ev_busy, al_busy, al_rise;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_d <= 1'b0;
      alarm_d <= 1'b0;
    end else begin
      fault_d <= fault_any;
      alarm_d <= s_alarm;
    end
  end
  assign al_rise = s_alarm && !alarm_d;
  assign ev_start = (fault_any && !fault_d) || al_rise;

  pulse_timer #(.LENGTH(EVENT_CYC), .WIDTH(32)) u_event (
    .clk(clk),
    .rst_n(rst_n),
    .start(ev_start),
    .busy(ev_busy)
  );

  pulse_timer #(.LENGTH(ALARM_CYC), .WIDTH(32)) u_alarm (
    .clk(clk),
    .rst_n(rst_n),
    .start(al_rise),
    .busy(al_busy)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      event_pulse_out_n <= 1'b1;
      alarm_indication <= 1'b0;
    end else begin
      event_pulse_out_n <= !(ev_start || ev_busy);
      alarm_indication <= al_rise && !al_busy;
    end
  end
endmodule : charger_ctrl
`default_nettype wire

// >>> testbench/charger_ctrl_properties.sv
// Concurrent checks on the charger control ports
`timescale 1ns/1ns
`default_nettype none
module charger_ctrl_properties #(
  parameter int unsigned EVENT_CYC = 20,
  parameter int unsigned ALARM_CYC = 50,
  parameter int unsigned OCP_CYC = 10
) (
  input wire logic clk, // Clock
  input wire logic rst_n, // Reset, active low
  input wire logic hiz_wr, // High-z strobe
  input wire logic hiz_wdata, // High-z value
  input wire logic fault_in, // Fault level
  input wire logic bat_ocp_in, // Battery overcurrent
  input wire logic adp_ovp1_in, // Adapter 1 overvoltage
  input wire logic bus_ucp_in, // Undercurrent
  input wire logic high_impedance_request, // High-z bit
  input wire logic charge_enable, // Charge bit
  input wire logic both_switch_disable, // Disable bit
  input wire logic converter_run, // Converter on
  input wire logic adc_run, // ADC on
  input wire logic internal_regulator_out, // Regulator on
  input wire logic gate_drive1, // Gate 1
  input wire logic gate_drive2, // Gate 2
  input wire logic input1_switch_fitted_flag, // Fitted 1
  input wire logic input2_switch_fitted_flag, // Fitted 2
  input wire logic host_port_ready, // Port ready
  input wire logic event_pulse_out_n, // Event pin
  input wire logic alarm_indication // Alarm pulse
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  int unsigned low_cnt;
  int unsigned gap_cnt;
  int unsigned ocp_cnt;
  // ****************************************************************
  // Pulse width, alarm spacing and overcurrent run counters
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt <= 0;
      gap_cnt <= ALARM_CYC;
      ocp_cnt <= 0;
    end else begin
      low_cnt <= event_pulse_out_n ? 0 : low_cnt + 1;
      gap_cnt <= alarm_indication ? 0 :
        (gap_cnt < ALARM_CYC ? gap_cnt + 1 : gap_cnt);
      ocp_cnt <= !bat_ocp_in ? 0 :
        (ocp_cnt < OCP_CYC + 8 ? ocp_cnt + 1 : ocp_cnt);
    end
  end
  chk_hiz_set: assert property (hiz_wr && hiz_wdata && host_port_ready &&
    $past(host_port_ready) |=> high_impedance_request)
    else $error("high-z write not taken");
  chk_hiz_off: assert property (high_impedance_request |=> !(gate_drive1 ||
    gate_drive2 || adc_run || internal_regulator_out || converter_run))
    else $error("high-z left an output on");
  chk_hiz_holds: assert property (high_impedance_request && !hiz_wr
    |=> high_impedance_request)
    else $error("high-z left without a write");
  chk_fault_stop: assert property (fault_in[*5]
    |-> !charge_enable && !converter_run)
    else $error("fault did not stop charging");
  chk_fault_reg: assert property ((host_port_ready &&
    !high_impedance_request)[*3] ##0 fault_in |-> internal_regulator_out)
    else $error("fault dropped the regulator");
  chk_event_len: assert property ($rose(event_pulse_out_n) |->
    low_cnt >= EVENT_CYC && low_cnt <= EVENT_CYC + 2)
    else $error("event pulse length wrong");
  chk_alarm_gap: assert property (alarm_indication |->
    gap_cnt >= ALARM_CYC - 2)
    else $error("alarms too close");
  chk_ocp_trip: assert property (ocp_cnt > OCP_CYC + 2
    |-> !charge_enable)
    else $error("overcurrent not acted on");
  chk_ovp_gate: assert property (adp_ovp1_in[*6] |-> !gate_drive1)
    else $error("overvoltage left gate on");
  chk_ucp_stop: assert property (bus_ucp_in[*6] |-> !charge_enable)
    else $error("undercurrent left charging on");
  chk_gate_fitted: assert property (!(gate_drive1 &&
    !input1_switch_fitted_flag) &&
    !(gate_drive2 && !input2_switch_fitted_flag))
    else $error("gate on without switch");
  chk_dis_gates: assert property ($past(both_switch_disable) |->
    !gate_drive1 && !gate_drive2)
    else $error("disable left gate on");
  chk_not_ready: assert property (!host_port_ready |-> !charge_enable &&
    !high_impedance_request && !gate_drive1 && !gate_drive2)
    else $error("activity before ready");
endmodule : charger_ctrl_properties
`default_nettype wire

// >>> testbench/charger_host_model.sv
// Host model that writes the control bits and watches alarms
`timescale 1ns/1ns
`default_nettype none
module charger_host_model (
  input wire logic clk, // Clock
  input wire logic bus_supply_present_flag, // Bus present
  input wire logic output_supply_present_flag, // Output present
  input wire logic alarm_indication, // Alarm pulse
  output logic hiz_wr, // High-z strobe
  output logic hiz_wdata, // High-z value
  output logic charge_enable_wr, // Charge strobe
  output logic charge_enable_wdata, // Charge value
  output logic dis_wr, // Disable strobe
  output logic dis_wdata, // Disable value
  output logic src_wr, // Source strobe
  output logic [1:0] src_wdata // Source value
);
  logic [3:0] wr = 4'h0;
  logic [1:0] wd = 2'h0;
  int alarm_seen = 0;
  assign hiz_wr = wr[0];
  assign charge_enable_wr = wr[1];
  assign dis_wr = wr[2];
  assign src_wr = wr[3];
  assign hiz_wdata = wd[0];
  assign charge_enable_wdata = wd[0];
  assign dis_wdata = wd[0];
  assign src_wdata = wd;
  // Alarms counted for the bench alarm check
  always @(posedge clk) if (alarm_indication === 1'h1) alarm_seen++;
  task automatic write(input int sel, input logic [1:0] val);
    @(posedge clk);
    #1;
    // Charge only once both supplies are seen
    if (sel == 1 && val[0] && !(bus_supply_present_flag === 1'h1 &&
      output_supply_present_flag === 1'h1)) return;
    wr[sel] = 1'h1;
    wd = val;
    @(posedge clk);
    #1;
    wr = 4'h0;
    wd = ~val;
  endtask : write
endmodule : charger_host_model
`default_nettype wire

// >>> testbench/test_charger_ctrl.sv
// Self-checking bench for the charger control block
`timescale 1ns/1ns
`default_nettype none
module test_charger_ctrl;
  logic clk = 1'h0, rst_n = 1'h0, fault_in = 1'h0, bat_ocp_in = 1'h0;
  logic adp_ovp1_in = 1'h0, adp_ovp2_in = 1'h0, bus_ucp_in = 1'h0;
  logic adp1_present_in = 1'h1, adp2_present_in = 1'h1, bus_present_in = 1'h0;
  logic adp1_tied_bus_in = 1'h0, adp2_tied_bus_in = 1'h0;
  logic out_present_in = 1'h0;
  logic gate1_grounded_in = 1'h0, gate2_grounded_in = 1'h0;
  logic alarm_event_in = 1'h0;
  wire logic hiz_wr, hiz_wdata, charge_enable_wr, charge_enable_wdata, dis_wr, dis_wdata;
  wire logic src_wr, high_impedance_request, charge_enable, adc_run;
  wire logic [1:0] src_wdata;
  wire logic both_switch_disable, converter_run, internal_regulator_out;
  wire logic gate_drive1, gate_drive2, host_port_ready, alarm_indication;
  wire logic input1_switch_fitted_flag, input2_switch_fitted_flag;
  wire logic bus_supply_present_flag, output_supply_present_flag;
  wire logic event_pulse_out_n;
  int errors = 0, comparisons = 0, cycles = 0;
  charger_ctrl #(.EVENT_CYC(20), .ALARM_CYC(50), .OCP_CYC(10)) uut (.*);
  charger_host_model host (.*);
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      print_verdict();
    end
  end
  // ****************************************************************
  // Checks, expectations and drivers
  // ****************************************************************
  task automatic check_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t bit got %b want %b", $time, got, exp);
    end
  endtask : check_bit
  task automatic check_cnt(input int got, input int exp);
    comparisons++;
    if (got != exp) begin
      errors++;
      $display("BAD %0t count got %0d want %0d", $time, got, exp);
    end
  endtask : check_cnt
  task automatic print_verdict();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // Input 1 first, input 2 only when input 1 cannot
  function automatic logic [1:0] exp_gates(input logic f1, input logic f2);
    return {f2 & ~f1, f1};
  endfunction : exp_gates
  task automatic power_up(input logic [1:0] gnd);
    rst_n = 1'h0;
    {gate2_grounded_in, gate1_grounded_in} = gnd;
    tick(4);
    check_bit(event_pulse_out_n, 1'h1);
    rst_n = 1'h1;
    for (int i = 0; i < 40 && host_port_ready !== 1'h1; i++) tick(1);
    check_bit(host_port_ready, 1'h1);
  endtask : power_up
  initial begin
    logic [1:0] want;
    int a0;
    a0 = $urandom(32'hB35C829C);
    for (int a = 0; a < 4; a++) begin
      adp1_tied_bus_in = a[0];
      power_up(a[1:0]);
      check_bit(input1_switch_fitted_flag, ~a[0]);
      check_bit(input2_switch_fitted_flag, ~a[1]);
      host.write(3, 2'h0);
      tick(4);
      want = exp_gates(~a[0], ~a[1]);
      check_bit(gate_drive1, want[0]);
      check_bit(gate_drive2, want[1]);
      host.write(3, 2'h2);
      tick(4);
      check_bit(gate_drive2, ~a[1]);
      check_bit(gate_drive1, 1'h0);
      host.write(3, 2'h0);
      host.write(2, 2'h3);
      tick(3);
      check_bit(both_switch_disable, 1'h1);
      check_bit(gate_drive1 | gate_drive2, 1'h0);
      host.write(2, 2'h0);
      adp_ovp1_in = 1'h1;
      tick(8);
      check_bit(gate_drive1, 1'h0);
      adp_ovp1_in = 1'h0;
      host.write(0, 2'h3);
      tick(3);
      check_bit(high_impedance_request, 1'h1);
      check_bit(gate_drive1 | gate_drive2 | adc_run, 1'h0);
      check_bit(converter_run, 1'h0);
      check_bit(internal_regulator_out, 1'h0);
      fault_in = 1'h1;
      tick(5 + $urandom % 8);
      fault_in = 1'h0;
      tick(30);
      check_bit(high_impedance_request, 1'h1);
      host.write(0, 2'h0);
      tick(4);
      check_bit(gate_drive1, want[0]);
      check_bit(internal_regulator_out, 1'h1);
      $display("arrangement %0d done", a);
    end
    power_up(2'h0);
    host.write(1, 2'h1);
    tick(2);
    check_bit(charge_enable, 1'h0);
    bus_present_in = 1'h1;
    out_present_in = 1'h1;
    tick(6);
    check_bit(bus_supply_present_flag & output_supply_present_flag, 1'h1);
    check_bit(gate_drive1, 1'h0);
    // Protection settings come before enabling charge
    host.write(2, 2'h0);
    for (int k = 0; k < 3; k++) begin
      host.write(1, 2'h1);
      tick(2);
      check_bit(charge_enable, 1'h1);
      check_bit(converter_run, 1'h1);
      {bat_ocp_in, bus_ucp_in, fault_in} = 3'(1 << k);
      tick(10);
      check_bit(event_pulse_out_n, 1'h0);
      host.write(1, 2'h1);
      tick(2 + $urandom % 8);
      check_bit(charge_enable, 1'h0);
      check_bit(internal_regulator_out, 1'h1);
      check_bit(high_impedance_request, 1'h0);
      {bat_ocp_in, bus_ucp_in, fault_in} = 3'h0;
      tick(30);
      check_bit(event_pulse_out_n, 1'h1);
    end
    host.write(1, 2'h1);
    bat_ocp_in = 1'h1;
    tick(3);
    bat_ocp_in = 1'h0;
    tick(10);
    check_bit(charge_enable, 1'h1);
    $display("faults done");
    a0 = host.alarm_seen;
    for (int n = 0; n < 3; n++) begin
      alarm_event_in = 1'h1;
      tick(2);
      alarm_event_in = 1'h0;
      tick(n == 1 ? 60 : 8);
    end
    tick(30);
    check_cnt(host.alarm_seen - a0, 2);
    $display("alarm done");
    print_verdict();
  end
endmodule : test_charger_ctrl
bind charger_ctrl charger_ctrl_properties #(.EVENT_CYC(EVENT_CYC),
  .ALARM_CYC(ALARM_CYC), .OCP_CYC(OCP_CYC)) chk (.*);
`default_nettype wire
